// File: rtl/rpp_port.sv
// Half-duplex two-wire serial port for point-to-point use.
// Assumes a 200 MHz clock; the line pin is split into in, out and enable.
// What this block does
// R1 - Transmit bytes queue in a 2x1024-byte store, then go out in order.
// R2 - Received bytes enter a 2x1024-byte store read by the processor.
// R3 - Protocol codes: 1 raw, 2 delimited, 3 3964R, 4 USS, 5 RTU, 6 ASCII.
// R4 - Character length code 0..3 gives five to eight data bits.
// R5 - Parity code 0 none, 1 odd, 2 even, generated and checked.
// R6 - Stop code 1 one, 2 one and a half, 3 two stop bits.
// R7 - Timeouts count bit periods at the selected line rate.
// R8 - Configuration returns a 16-bit result code, zero when accepted.
// R9 - Modes 3 to 6 hold ack_wait_o after each frame until a partner character arrives or the next frame starts; 1 and 2 never.
// R10 - In modes 3 to 6, send status shows whether the partner acknowledged the last transfer.
// R11 - In master modes the processor reads the reply after each send.
// R12 - Framing of the delimited protocol (mode 2) is added by the port itself.
// R13 - Raw mode ignores the parameter block; other modes take parameters from it.
// R14 - Block bytes 0,1 start ids, 2,3 end ids, word at 4 timeout.
// R15 - Half duplex: never transmit while receiving.
// R16 - Line rate at most 115.2 kilobaud.
// R17 - After reset the line is in fieldbus mode until configured otherwise.
// R18 - Point-to-point use starts only after boot with that function selected.
// R19 - Rate codes 04h..0Eh map 1200 to 115200 baud.
// R20 - Flow setting ignored; direction output low sending, high receiving.
// R21 - Start and end ids valid only from 01h to 1Fh.
// R22 - Low start bit, data LSB first, parity, then high stop bits.
`timescale 1ns/100ps
module rpp_port (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        boot_done_i,
  input  wire logic        point_to_point_select_i,
  input  wire logic        config_call_i,
  input  wire logic [7:0]  protocol_i,
  input  wire logic [47:0] param_block_i,
  input  wire logic [7:0]  baud_code_i,
  input  wire logic [7:0]  char_length_code_i,
  input  wire logic [7:0]  parity_code_i,
  input  wire logic [7:0]  stop_bit_code_i,
  output logic      [15:0] result_code_o,
  output logic             config_done_o,
  output logic             point_to_point_o,
  output logic             fieldbus_mode_o,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_last_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  output logic             tx_busy_o,
  output logic             ack_wait_o,
  output logic             ack_seen_o,
  output logic      [7:0]  rx_data_o,
  output logic             rx_frame_end_o,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output logic             rx_error_o,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe_o,
  output logic             rts_o
);
  typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
                            TX_PAR = 3'h2, TX_STOP = 3'h6} rpp_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
                            RX_PAR = 3'h2, RX_STOP = 3'h6} rpp_rx_st_t;
  typedef enum logic [2:0] {PH_SID1 = 3'h0, PH_SID2 = 3'h1, PH_BODY = 3'h3,
                            PH_EID1 = 3'h2, PH_EID2 = 3'h6, PH_DONE = 3'h7} rpp_ph_t;
  typedef struct packed {
    logic                      s1;
    logic                      s2;
    logic                      p2p;
    logic                      fb;
    logic [7:0]                proto;
    logic [rpp_pkg::DIV_W-1:0] div;
    logic [1:0]                clen;
    logic [1:0]                par;
    logic [1:0]                stop;
    logic [7:0]                sid1;
    logic [7:0]                sid2;
    logic [7:0]                eid1;
    logic [7:0]                eid2;
    logic [15:0]               tmo;
    logic [15:0]               result;
    logic                      cfg_done;
    rpp_tx_st_t                tst;
    rpp_ph_t                   tph;
    logic [19:0]               tcnt;
    logic [2:0]                tbit;
    logic [7:0]                tsh;
    logic                      tpar;
    logic                      txd;
    logic                      oe;
    logic                      rts;
    logic                      busy;
    logic                      wait_ack;
    logic                      ack_seen;
    rpp_rx_st_t                rst;
    logic [rpp_pkg::DIV_W-1:0] rcnt;
    logic [2:0]                rbit;
    logic [7:0]                rsh;
    logic                      rpar;
    logic                      rbad;
    logic [15:0]               idle_bits;
    logic                      rx_any;
    logic                      push_v;
    logic [8:0]                push_w;
    logic                      err;
  } rpp_port_st_t;

  localparam rpp_port_st_t RST_ST = '{tst: TX_IDLE, rst: RX_IDLE, tph: PH_SID1, fb: 1'b1,
                                      txd: 1'b1, rts: 1'b1, s1: 1'b1, s2: 1'b1, default: '0};

  rpp_port_st_t q;
  rpp_port_st_t d;
  logic         tx_pop;
  logic [2:0]   bits_last;

  rpp_stream_if #(.W(rpp_pkg::WORD_W)) tx_in ();
  rpp_stream_if #(.W(rpp_pkg::WORD_W)) tx_out ();
  rpp_stream_if #(.W(rpp_pkg::WORD_W)) rx_in ();
  rpp_stream_if #(.W(rpp_pkg::WORD_W)) rx_mid ();
  rpp_stream_if #(.W(rpp_pkg::WORD_W)) rx_out ();

  assign tx_in.data   = {tx_last_i, tx_data_i};
  assign tx_in.valid  = tx_valid_i;
  assign tx_out.ready = tx_pop;
  assign rx_in.valid  = q.push_v;
  assign rx_in.data   = q.push_w;
  assign rx_out.ready = rx_ready_i;

  rpp_fifo #(.W(rpp_pkg::WORD_W), .DEPTH(rpp_pkg::FIFO_DEPTH)) u_tx_fifo ( // R1
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .wr_s      (tx_in),
    .rd_s      (tx_out)
  );
  rpp_fifo #(.W(rpp_pkg::WORD_W), .DEPTH(rpp_pkg::FIFO_DEPTH)) u_rx_fifo ( // R2
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .wr_s      (rx_in),
    .rd_s      (rx_mid)
  );
  rpp_buf2 #(.W(rpp_pkg::WORD_W)) u_rx_buf (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .in_s      (rx_mid),
    .out_s     (rx_out)
  );

  function automatic logic id_ok(input logic [7:0] b);
    return b >= rpp_pkg::ID_MIN && b <= rpp_pkg::ID_MAX; // R21
  endfunction

  function automatic logic [rpp_pkg::DIV_W-1:0] div_of(input logic [7:0] code);
    logic [rpp_pkg::DIV_W-1:0] r;
    r = '0;
    for (int i = 0; i < 11; i++) begin
      if (code == 8'(i) + rpp_pkg::BAUD_CODE_MIN) begin // R19 R16
        r = rpp_pkg::DIV_W'(rpp_pkg::CLK_HZ / rpp_pkg::BAUD_RATE[i]);
      end
    end
    return r;
  endfunction

  assign bits_last = 3'(3'h4 + {1'b0, q.clen}); // R4

  always_comb begin
    logic [15:0] rc;
    logic [7:0]  tb;
    logic [7:0]  rxb;
    logic [7:0]  last_eid;
    logic [19:0] bit_len;
    logic [19:0] stop_len;
    logic        tx_go;
    logic        delim;
    logic        ack_mode;
    logic        has_end;
    rc       = rpp_pkg::RC_OK;
    tb       = '0;
    rxb      = '0;
    tx_go    = 1'b0;
    tx_pop   = 1'b0;
    d        = q;
    d.cfg_done = 1'b0;
    d.push_v = 1'b0;
    d.err    = q.push_v && !rx_in.ready;
    d.s1     = rxd_i;
    d.s2     = q.s1;
    delim    = q.proto == rpp_pkg::PROTO_DELIM;
    ack_mode = q.proto >= rpp_pkg::PROTO_3964R && q.proto <= rpp_pkg::PROTO_MB_ASC; // R9
    has_end  = id_ok(q.eid1) || id_ok(q.eid2);
    last_eid = id_ok(q.eid2) ? q.eid2 : q.eid1;
    bit_len  = 20'(q.div) - 20'h1;
    case (q.stop) // R6
      rpp_pkg::STOP_TWO:      stop_len = 20'(q.div) + 20'(q.div) - 20'h1;
      rpp_pkg::STOP_ONE_HALF: stop_len = 20'(q.div) + 20'(q.div >> 1) - 20'h1;
      default:                stop_len = bit_len;
    endcase

    if (config_call_i) begin // R8
      if (!boot_done_i || !point_to_point_select_i) rc = rpp_pkg::RC_NO_IF; // R18
      else if (protocol_i < rpp_pkg::PROTO_RAW || protocol_i > rpp_pkg::PROTO_MB_ASC)
        rc = rpp_pkg::RC_PROTO; // R3
      else if (baud_code_i < rpp_pkg::BAUD_CODE_MIN || baud_code_i > rpp_pkg::BAUD_CODE_MAX)
        rc = rpp_pkg::RC_BAUD; // R19
      else if (char_length_code_i > rpp_pkg::CHAR_CODE_MAX) rc = rpp_pkg::RC_CHAR;
      else if (parity_code_i > 8'(rpp_pkg::PAR_EVEN)) rc = rpp_pkg::RC_PARITY; // R5
      else if (stop_bit_code_i < 8'(rpp_pkg::STOP_ONE) || stop_bit_code_i > 8'(rpp_pkg::STOP_TWO))
        rc = rpp_pkg::RC_STOP;
      d.result   = rc;
      d.cfg_done = 1'b1;
      if (rc == rpp_pkg::RC_OK) begin // R17
        d.p2p   = 1'b1;
        d.fb    = 1'b0;
        d.proto = protocol_i;
        d.div   = div_of(baud_code_i);
        d.clen  = char_length_code_i[1:0];
        d.par   = parity_code_i[1:0];
        d.stop  = stop_bit_code_i[1:0];
        d.sid1  = '0;
        d.sid2  = '0;
        d.eid1  = '0;
        d.eid2  = '0;
        d.tmo   = {param_block_i[8*rpp_pkg::TIMEOUT_WORD_SLOT +: 8],
                   param_block_i[8*(rpp_pkg::TIMEOUT_WORD_SLOT+1) +: 8]}; // R14 R7
        if (protocol_i != rpp_pkg::PROTO_RAW) begin // R13
          d.sid1 = param_block_i[8*rpp_pkg::PB_FIRST_START +: 8]; // R14
          d.sid2 = param_block_i[8*rpp_pkg::PB_SECOND_START +: 8];
          d.eid1 = param_block_i[8*rpp_pkg::PB_FIRST_END +: 8];
          d.eid2 = param_block_i[8*rpp_pkg::PB_SECOND_END +: 8];
        end
      end
    end

    if (q.tcnt != '0) d.tcnt = q.tcnt - 20'h1;
    case (q.tst)
      TX_IDLE: if (q.p2p && q.rst == RX_IDLE && q.s2) begin // R15
        case (q.tph) // R12
          PH_SID1: if (tx_out.valid) begin
            d.tph      = PH_SID2;
            d.busy     = 1'b1;
            d.ack_seen = 1'b0;
            d.wait_ack = 1'b0;
            tx_go      = delim && id_ok(q.sid1);
            tb         = q.sid1;
          end
          PH_SID2: begin
            d.tph = PH_BODY;
            tx_go = delim && id_ok(q.sid2);
            tb    = q.sid2;
          end
          PH_BODY: if (tx_out.valid) begin // R1
            tx_pop = 1'b1;
            tx_go  = 1'b1;
            tb     = tx_out.data[7:0];
            d.tph  = tx_out.data[8] ? PH_EID1 : PH_BODY;
          end
          PH_EID1: begin
            d.tph = PH_EID2;
            tx_go = delim && id_ok(q.eid1);
            tb    = q.eid1;
          end
          PH_EID2: begin
            d.tph = PH_DONE;
            tx_go = delim && id_ok(q.eid2);
            tb    = q.eid2;
          end
          default: begin
            d.tph      = PH_SID1;
            d.busy     = 1'b0;
            d.wait_ack = ack_mode; // R9 R10
          end
        endcase
      end
      TX_START: if (q.tcnt == '0) begin
        d.tst  = TX_DATA;
        d.tcnt = bit_len;
      end
      TX_DATA: if (q.tcnt == '0) begin // R22
        d.tpar = q.tpar ^ q.tsh[0]; // R5
        d.tsh  = q.tsh >> 1;
        d.tcnt = bit_len;
        d.tbit = q.tbit + 3'h1;
        if (q.tbit == bits_last) begin // R4
          d.tst  = (q.par == rpp_pkg::PAR_NONE) ? TX_STOP : TX_PAR;
          d.tcnt = (q.par == rpp_pkg::PAR_NONE) ? stop_len : bit_len;
        end
      end
      TX_PAR: if (q.tcnt == '0) begin
        d.tst  = TX_STOP;
        d.tcnt = stop_len; // R6
      end
      TX_STOP: if (q.tcnt == '0) d.tst = TX_IDLE;
      default: d.tst = TX_IDLE;
    endcase
    if (tx_go) begin // R22
      d.tst  = TX_START;
      d.tsh  = tb;
      d.tcnt = bit_len;
      d.tbit = '0;
      d.tpar = q.par == rpp_pkg::PAR_ODD;
    end
    d.txd = !(d.tst == TX_START) && (d.tst == TX_DATA ? d.tsh[0] :
             d.tst == TX_PAR ? d.tpar : 1'b1); // R22
    d.oe  = d.tst != TX_IDLE;
    d.rts = !d.oe; // R20

    if (q.rcnt != '0) d.rcnt = q.rcnt - 1'b1;
    case (q.rst)
      RX_IDLE: if (q.p2p && q.tst == TX_IDLE && !q.s2) begin // R15
        d.rst       = RX_START;
        d.rcnt      = q.div >> 1;
        d.idle_bits = '0;
      end else if (delim && q.rx_any && !has_end && q.rcnt == '0) begin // R7
        d.rcnt      = q.div - 1'b1;
        d.idle_bits = q.idle_bits + 16'h1;
        if (d.idle_bits >= q.tmo) begin
          d.push_v    = 1'b1;
          d.push_w    = {1'b1, 8'h00};
          d.rx_any    = 1'b0;
          d.idle_bits = '0;
        end
      end
      RX_START: if (q.rcnt == '0) begin
        d.rst  = q.s2 ? RX_IDLE : RX_DATA;
        d.rcnt = q.div - 1'b1;
        d.rbit = '0;
        d.rsh  = '0;
        d.rpar = q.par == rpp_pkg::PAR_ODD;
        d.rbad = 1'b0;
      end
      RX_DATA: if (q.rcnt == '0) begin
        d.rsh  = {q.s2, q.rsh[7:1]};
        d.rpar = q.rpar ^ q.s2;
        d.rcnt = q.div - 1'b1;
        d.rbit = q.rbit + 3'h1;
        if (q.rbit == bits_last) d.rst = (q.par == rpp_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
      end
      RX_PAR: if (q.rcnt == '0) begin
        d.rbad = q.s2 != q.rpar; // R5
        d.rst  = RX_STOP;
        d.rcnt = q.div - 1'b1;
      end
      RX_STOP: if (q.rcnt == '0) begin
        d.rst = RX_IDLE;
        d.err = q.rbad || !q.s2 || d.err;
        rxb   = q.rsh >> (2'h3 - q.clen);
        if (q.wait_ack) begin // R9 R10
          d.wait_ack = 1'b0;
          d.ack_seen = 1'b1;
        end
        if (delim && has_end && rxb == last_eid) begin // R21
          d.push_v = 1'b1;
          d.push_w = {1'b1, 8'h00};
          d.rx_any = 1'b0;
        end else if (!(delim && (rxb == q.sid1 || rxb == q.sid2 || rxb == q.eid1 ||
                                 rxb == q.eid2) && id_ok(rxb))) begin // R2
          d.push_v = 1'b1;
          d.push_w = {1'b0, rxb};
          d.rx_any = delim;
          d.rcnt   = q.div - 1'b1; // R7
        end
      end
      default: d.rst = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) q <= RST_ST;
    else q <= d;
  end

  assign result_code_o    = q.result;
  assign config_done_o    = q.cfg_done;
  assign point_to_point_o = q.p2p;
  assign fieldbus_mode_o  = q.fb;
  assign tx_ready_o       = tx_in.ready;
  assign tx_busy_o        = q.busy;
  assign ack_wait_o       = q.wait_ack;
  assign ack_seen_o       = q.ack_seen;
  assign rx_data_o        = rx_out.data[7:0];
  assign rx_frame_end_o   = rx_out.data[8];
  assign rx_valid_o       = rx_out.valid;
  assign rx_error_o       = q.err;
  assign txd_o            = q.txd;
  assign txd_oe_o         = q.oe;
  assign rts_o            = q.rts;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  oe_idle_a: assert property (!point_to_point_o |-> !txd_oe_o) // R17
    else $error("Line driven outside point-to-point use");
  dir_level_a: assert property (rts_o == !txd_oe_o) // R20
    else $error("Direction output disagrees with drive state");
  half_duplex_a: assert property (q.rst != RX_IDLE |-> !txd_oe_o) // R15
    else $error("Transmitting while receiving");
  start_bit_a: assert property ($rose(txd_oe_o) |-> !txd_o) // R22
    else $error("Character does not open with a low start bit");
  stop_high_a: assert property (q.tst == TX_STOP |-> txd_o && txd_oe_o) // R6
    else $error("Stop bit not at idle level");
  bit_count_a: assert property (q.tst != TX_DATA && $past(q.tst) == TX_DATA // R4
    |-> $past(q.tbit) == bits_last)
    else $error("Wrong number of data bits sent");
  bad_proto_a: assert property (config_call_i && boot_done_i && point_to_point_select_i // R3
    && protocol_i == 8'h00 |=> result_code_o == rpp_pkg::RC_PROTO && config_done_o)
    else $error("Protocol code zero not refused");
  boot_gate_a: assert property (!point_to_point_o && !boot_done_i |=> !point_to_point_o) // R18
    else $error("Point-to-point entered before boot");
  ack_cause_a: assert property ($rose(ack_seen_o) |-> $past(ack_wait_o)) // R9
    else $error("Acknowledge seen without a pending transfer");

  frame_sent_c: cover property ($fell(tx_busy_o));
  ack_seen_c: cover property ($rose(ack_seen_o));
  rx_end_c: cover property (rx_valid_o && rx_frame_end_o && rx_ready_i);
endmodule

// File: rtl/rpp_pkg.sv
// Constants shared by the half-duplex serial port and its buffers.
// Assumes a 200 MHz system clock and a two-wire half-duplex line.
package rpp_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  // Line rates for codes 04h..0Eh, in order
  localparam int unsigned BAUD_RATE [11] = '{1200, 1800, 2400, 4800, 7200, 9600, 14400,
                                              19200, 38400, 57600, 115200};
  localparam logic [7:0]  BAUD_CODE_MIN = 8'h04;
  localparam logic [7:0]  BAUD_CODE_MAX = 8'h0e;
  localparam int          DIV_W         = 18;

  localparam logic [7:0]  PROTO_RAW     = 8'h01;
  localparam logic [7:0]  PROTO_DELIM   = 8'h02;
  localparam logic [7:0]  PROTO_3964R   = 8'h03;
  localparam logic [7:0]  PROTO_USS     = 8'h04;
  localparam logic [7:0]  PROTO_MB_RTU  = 8'h05;
  localparam logic [7:0]  PROTO_MB_ASC  = 8'h06;

  localparam logic [7:0]  CHAR_CODE_MAX = 8'h03;
  localparam logic [1:0]  PAR_NONE      = 2'h0;
  localparam logic [1:0]  PAR_ODD       = 2'h1;
  localparam logic [1:0]  PAR_EVEN      = 2'h2;
  localparam logic [1:0]  STOP_ONE      = 2'h1;
  localparam logic [1:0]  STOP_ONE_HALF = 2'h2;
  localparam logic [1:0]  STOP_TWO      = 2'h3;

  localparam logic [7:0]  ID_MIN        = 8'h01;
  localparam logic [7:0]  ID_MAX        = 8'h1f;
  // Byte offsets inside the delimited-frame parameter block
  localparam int          PB_FIRST_START    = 0;
  localparam int          PB_SECOND_START   = 1;
  localparam int          PB_FIRST_END      = 2;
  localparam int          PB_SECOND_END     = 3;
  localparam int          TIMEOUT_WORD_SLOT = 4;
  localparam int          PB_BYTES          = 6;

  localparam logic [15:0] RC_OK         = 16'h0000;
  localparam logic [15:0] RC_NO_IF      = 16'h809a;
  localparam logic [15:0] RC_PROTO      = 16'h8124;
  localparam logic [15:0] RC_PARAM      = 16'h8224;
  localparam logic [15:0] RC_BAUD       = 16'h8324;
  localparam logic [15:0] RC_CHAR       = 16'h8424;
  localparam logic [15:0] RC_PARITY     = 16'h8524;
  localparam logic [15:0] RC_STOP       = 16'h8624;

  localparam int          FIFO_HALF     = 1024;
  localparam int          FIFO_DEPTH    = 2 * FIFO_HALF;
  localparam int          WORD_W        = 9;
endpackage

// File: rtl/rpp_stream_if.sv
// Valid/ready word stream between the port's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface rpp_stream_if #(parameter int W = 9) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// File: rtl/rpp_fifo.sv
// First-in-first-out store of DEPTH words with registered full and empty.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module rpp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 2048
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rstn_i,
  rpp_stream_if.snk  wr_s,
  rpp_stream_if.src  rd_s
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          full;
    logic          empty;
  } rpp_fifo_st_t;

  rpp_fifo_st_t q;
  rpp_fifo_st_t d;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  assign push       = wr_s.valid && !q.full;
  assign pop        = rd_s.ready && !q.empty;
  assign wr_s.ready = !q.full;
  assign rd_s.valid = !q.empty;
  assign rd_s.data  = mem[q.rp];

  always_comb begin
    d = q;
    if (push) d.wp = q.wp + 1'b1;
    if (pop) d.rp = q.rp + 1'b1;
    d.cnt   = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.full  = d.cnt == (AW+1)'(DEPTH);
    d.empty = d.cnt == '0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) q <= '{empty: 1'b1, default: '0};
    else q <= d;
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) mem[q.wp] <= wr_s.data;
  end
endmodule

// File: rtl/rpp_buf2.sv
// Two-entry buffer: a stall downstream never drops an accepted word.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module rpp_buf2 #(
  parameter int W = 9
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rstn_i,
  rpp_stream_if.snk  in_s,
  rpp_stream_if.src  out_s
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic         v0;
    logic         v1;
  } rpp_buf2_st_t;

  rpp_buf2_st_t q;
  rpp_buf2_st_t d;

  assign in_s.ready  = !q.v1;
  assign out_s.valid = q.v0;
  assign out_s.data  = q.d0;

  always_comb begin
    d = q;
    if (out_s.ready && q.v0) begin
      d.d0 = q.d1;
      d.v0 = q.v1;
      d.v1 = 1'b0;
    end
    if (in_s.valid && !q.v1) begin
      if (!d.v0) begin
        d.d0 = in_s.data;
        d.v0 = 1'b1;
      end else begin
        d.d1 = in_s.data;
        d.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) q <= '0;
    else q <= d;
  end
endmodule

// File: tb/rpp_station.sv
// Remote station on the two-wire line: sends and decodes 8N1 characters.
// Assumes the bench resolves the line and biases it high when released.
`timescale 1ns/100ps
module rpp_station #(parameter int BIT_NS = 8680) (
  input  wire logic line_i,
  output logic      drv_o
);
  initial drv_o = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    drv_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      drv_o = b[i];
      #(BIT_NS);
    end
    drv_o = 1'b1;
    #(BIT_NS);
  endtask
  task automatic get_byte(output logic [7:0] b, output logic stop);
    @(negedge line_i);
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      b[i] = line_i;
    end
    #(BIT_NS);
    stop = line_i;
  endtask
endmodule

// File: tb/rpp_port_tb_top.sv
// Self-checking bench for the half-duplex serial port.
// Assumes rpp_station as the remote party at 115200 baud.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module rpp_port_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        boot = 1'b0, sel = 1'b0, call = 1'b0, txv = 1'b0, rxr = 1'b0;
  logic [7:0]  proto = 8'h01, baud = 8'h0e, clen = 8'h03, par = 8'h00, stp = 8'h01;
  logic [7:0]  txd = 8'h00, got, rxdat;
  logic [15:0] rc;
  logic [47:0] pblk = 48'h0;
  logic        rxe_seen = 1'b0;
  logic        line, drv, stop, done, p2p, fbm, txr, busy, aw, as, rxfe, rxv, rxe;
  logic        txo, oe, rts;
  int          error_cnt = 0;
  int          n_compared = 0;
  logic [55:0] bad [8] = '{56'h000e0300018124, 56'h070e0300018124, 56'h01030300018324,
    56'h010f0300018324, 56'h010e0400018424, 56'h010e0003018524, 56'h010e0300008624,
    56'h010e0300048624};
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (rxe === 1'b1) rxe_seen <= 1'b1;
  assign line = oe ? txo : drv;
  rpp_port dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .boot_done_i(boot),
    .point_to_point_select_i(sel), .config_call_i(call), .protocol_i(proto),
    .param_block_i(pblk), .baud_code_i(baud), .char_length_code_i(clen),
    .parity_code_i(par), .stop_bit_code_i(stp), .result_code_o(rc),
    .config_done_o(done), .point_to_point_o(p2p), .fieldbus_mode_o(fbm),
    .tx_data_i(txd), .tx_last_i(1'b1), .tx_valid_i(txv), .tx_ready_o(txr),
    .tx_busy_o(busy), .ack_wait_o(aw), .ack_seen_o(as), .rx_data_o(rxdat),
    .rx_frame_end_o(rxfe), .rx_valid_o(rxv), .rx_ready_i(rxr), .rx_error_o(rxe),
    .rxd_i(line), .txd_o(txo), .txd_oe_o(oe), .rts_o(rts));
  rpp_station #(.BIT_NS(8680)) station (.line_i(line), .drv_o(drv));
  task automatic give_verdict;
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cfg(input logic [7:0] p, b, l, q, s, input logic [15:0] e);
    proto = p; baud = b; clen = l; par = q; stp = s; call = 1'b1;
    @(posedge clk_sys_i);
    #1 call = 1'b0;
    `CHK("config_done", 1'b1, done)
    `CHK("result_code", e, rc)
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic put(input logic [7:0] b);
    txd = b; txv = 1'b1;
    @(posedge clk_sys_i);
    while (txr !== 1'b1) @(posedge clk_sys_i);
    #1 txv = 1'b0;
  endtask
  task automatic take(input logic [8:0] e);
    int n;
    n = 0;
    while (rxv !== 1'b1 && n < 30000) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK("rx_valid", 1'b1, rxv)
    `CHK("rx_data", e[7:0], rxdat)
    `CHK("rx_frame_end", e[8], rxfe)
    rxr = 1'b1;
    @(posedge clk_sys_i);
    #1 rxr = 1'b0;
    `CHK("rx_drained", 1'b0, rxv)
  endtask
  initial begin
    #480000 error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    `CHK("tx_ready", 1'b1, txr)
    `CHK("rts", 1'b1, rts)
    `CHK("txd_oe", 1'b0, oe)
    `CHK("fieldbus", 1'b1, fbm)
    sel = 1'b1;
    cfg(8'h01, 8'h0e, 8'h03, 8'h00, 8'h01, 16'h809a);
    boot = 1'b1;
    foreach (bad[i])
      cfg(bad[i][55:48], bad[i][47:40], bad[i][39:32], bad[i][31:24], bad[i][23:16],
        bad[i][15:0]);
    `CHK("p2p_refused", 1'b0, p2p)
    for (int p = 1; p <= 6; p++)
      cfg(8'(p), 8'h04, 8'h00, 8'h02, 8'h03, 16'h0000);
    cfg(8'h01, 8'h0e, 8'h03, 8'h00, 8'h01, 16'h0000);
    `CHK("p2p", 1'b1, p2p)
    `CHK("fieldbus_off", 1'b0, fbm)
    for (int k = 0; k < 2; k++) begin
      if (k == 1)
        cfg(8'h04, 8'h0e, 8'h03, 8'h00, 8'h01, 16'h0000);
      fork
        station.get_byte(got, stop);
        put(8'ha5 ^ 8'(k));
        begin
          wait (oe === 1'b1);
          #1;
          `CHK("rts_sending", 1'b0, rts)
          `CHK("tx_busy", 1'b1, busy)
        end
      join
      `CHK("line_byte", 8'ha5 ^ 8'(k), got)
      `CHK("stop_level", 1'b1, stop)
      repeat (2000) @(posedge clk_sys_i);
      #1;
      `CHK("ack_wait", 1'(k), aw)
      `CHK("tx_idle", 1'b0, busy)
      `CHK("ack_seen", 1'b0, as)
      station.send_byte(8'h3c + 8'(k));
      `CHK("ack_wait_end", 1'b0, aw)
      `CHK("ack_seen_set", 1'(k), as)
      take({1'b0, 8'h3c + 8'(k)});
    end
    // Delimited mode: out-of-range end id, one bit period of silence ends the frame
    pblk = 48'h0100003c0000;
    cfg(8'h02, 8'h0e, 8'h03, 8'h00, 8'h01, 16'h0000);
    station.send_byte(8'h3c);
    take(9'h03c);
    take(9'h100);
    `CHK("rx_error", 1'b0, rxe_seen)
    give_verdict();
  end
endmodule
